// ### common/hbgp_pkg.sv
// Shared constants and types for the half-bridge gate protection block
`default_nettype none
package hbgp_pkg;

  // ----------------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;

  // ----------------------------------------------------------------------
  // Times as specified
  // ----------------------------------------------------------------------
  localparam int FILT_REJECT_NS = 625;
  localparam int FILT_PASS_NS   = 750;
  localparam int DEAD_TIME_NS   = 2000;
  localparam int ERR_RESET_NS   = 9000;
  localparam int BLANKING_NS    = 2310;

  // ----------------------------------------------------------------------
  // Derived cycle counts (least times round up)
  // ----------------------------------------------------------------------
  localparam int FILT_CYC  = (FILT_REJECT_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int DEAD_CYC  = (DEAD_TIME_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  // Strictly longer than the reset interval
  localparam int CLR_CYC   = ERR_RESET_NS / CLK_PERIOD_NS + 1;
  localparam int BLANK_CYC = (BLANKING_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;

  localparam int CNT_W = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic GATE_RST = 1'b0;
  localparam logic ERR_RST  = 1'b0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic high;
    logic low;
  } hbgp_pair_t;

  typedef enum logic [1:0] {
    HBGP_IDLE   = 2'b00,
    HBGP_BLANK  = 2'b01,
    HBGP_WATCH  = 2'b10,
    HBGP_TRIP   = 2'b11
  } hbgp_desat_st_t;

endpackage : hbgp_pkg
`default_nettype wire

// ### src/hbgp_glitch_filter.sv
// Input glitch filter: a level change must hold for a set number of samples
`default_nettype none
module hbgp_glitch_filter
  import hbgp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Data
  input  wire logic din,
  output logic      dout
);

  logic [CNT_W-1:0] cnt;

  // ----------------------------------------------------------------------
  // Stability counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (din == dout) begin
      cnt <= '0;
    end else if (cnt == CNT_W'(FILT_CYC - 1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Accepted level
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'b0;
    end else if (din != dout && cnt == CNT_W'(FILT_CYC - 1)) begin
      dout <= din; // R4 R5
    end
  end

endmodule : hbgp_glitch_filter
`default_nettype wire

// ### src/hbgp_desat_guard.sv
// Desaturation guard for one switch: blanking after turn-on, then watch
`default_nettype none
module hbgp_desat_guard
  import hbgp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Switch state and comparator
  input  wire logic gate_on,
  input  wire logic desat,
  // Result
  output logic      trip
);

  hbgp_desat_st_t   state;
  logic [CNT_W-1:0] cnt;

  // ----------------------------------------------------------------------
  // Guard sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= HBGP_IDLE;
    end else begin
      case (state)
        HBGP_IDLE: begin
          if (gate_on) state <= HBGP_BLANK;
        end
        HBGP_BLANK: begin
          if (!gate_on) state <= HBGP_IDLE;
          else if (cnt == CNT_W'(BLANK_CYC - 1)) state <= HBGP_WATCH; // R14
        end
        HBGP_WATCH: begin
          if (!gate_on) state <= HBGP_IDLE;
          else if (desat) state <= HBGP_TRIP; // R15
        end
        HBGP_TRIP: begin
          if (!gate_on) state <= HBGP_IDLE;
        end
        default: state <= HBGP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Blanking counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (state == HBGP_BLANK) begin
      cnt <= cnt + 1'b1;
    end else begin
      cnt <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Trip pulse
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip <= 1'b0;
    end else begin
      trip <= (state == HBGP_WATCH) && gate_on && desat; // R15
    end
  end

endmodule : hbgp_desat_guard
`default_nettype wire

// ### src/hbgp_top.sv
// Half-bridge gate protection: filter, interlock, supervision, fault flag
//
// Operation
// [R1] Undervoltage forces both gates off
// [R2] Undervoltage ignores all switching commands
// [R3] Undervoltage sets error latch and fault flag
// [R4] Reject pulses under 625 ns, pass over 750 ns
// [R5] Pulses in between may pass or not
// [R6] Never both switches on together
// [R7] Gap is max of internal and controller
// [R8] Internal dead time fixed at 2 us
// [R9] Controller may drive complementary single signal
// [R10] Both commands high turns both off
// [R11] Single switching channel gets no dead time
// [R12] Overlap never raises error or fault flag
// [R13] Latency is dead time plus propagation
// [R14] Desaturation watch waits out blanking interval
// [R15] Desaturation trips switch, latch and flag
// [R16] Tie sense to return to disable
// [R17] Error latch blocks commands, gates stay off
// [R18] Clear latch after both low past 9 us
// [R19] Fault flag low when no error
// [R20] Shutdown low forces gates off
// [R21] Internal clock samples and times everything
`default_nettype none
module hbgp_top
  import hbgp_pkg::*;
(
  // Clock and reset
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  // Controller commands
  input  wire logic HIGH_SIDE_COMMAND_IN,
  input  wire logic LOW_SIDE_COMMAND_IN,
  // Shutdown request, low forces off
  input  wire logic SHUTDOWN_REQUEST_IN_N,
  // Supervision comparators
  input  wire logic SUPPLY_UNDERVOLTAGE,
  input  wire logic HIGH_SIDE_COLLECTOR_SENSE,
  input  wire logic LOW_SIDE_COLLECTOR_SENSE,
  // Gate drive
  output logic      HIGH_SIDE_GATE_ON_OUT,
  output logic      HIGH_SIDE_GATE_OFF_OUT,
  output logic      LOW_SIDE_GATE_ON_OUT,
  output logic      LOW_SIDE_GATE_OFF_OUT,
  // Open-collector fault flag
  input  wire logic FAULT_FLAG_IN,
  output logic      FAULT_FLAG_OUT,
  output logic      FAULT_FLAG_OE_N
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  hbgp_pair_t sync1_cmd;
  hbgp_pair_t sync2_cmd;
  logic [3:0] sync1_mon;
  logic [3:0] sync2_mon;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_cmd <= '0;
      sync2_cmd <= '0;
    end else begin
      sync1_cmd <= '{high: HIGH_SIDE_COMMAND_IN, low: LOW_SIDE_COMMAND_IN};
      sync2_cmd <= sync1_cmd; // R21
    end
  end

  // Shutdown resets as asserted, undervoltage as present
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_mon <= 4'h4;
      sync2_mon <= 4'h4;
    end else begin
      sync1_mon <= {SHUTDOWN_REQUEST_IN_N, SUPPLY_UNDERVOLTAGE,
                    HIGH_SIDE_COLLECTOR_SENSE, LOW_SIDE_COLLECTOR_SENSE};
      sync2_mon <= sync1_mon;
    end
  end

  logic shutdown_n;
  logic undervolt;
  logic hs_sense;
  logic ls_sense;

  assign shutdown_n = sync2_mon[3];
  assign undervolt  = sync2_mon[2];
  assign hs_sense   = sync2_mon[1];
  assign ls_sense   = sync2_mon[0];

  // ----------------------------------------------------------------------
  // Input glitch filters
  // ----------------------------------------------------------------------
  hbgp_pair_t filt_cmd;

  hbgp_glitch_filter u_filt_high (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .din   (sync2_cmd.high),
    .dout  (filt_cmd.high)
  );

  hbgp_glitch_filter u_filt_low (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .din   (sync2_cmd.low),
    .dout  (filt_cmd.low)
  );

  // ----------------------------------------------------------------------
  // Requested states
  // ----------------------------------------------------------------------
  logic err_latch;
  logic block;
  logic want_high;
  logic want_low;

  // Any protection condition overrides commands
  assign block = err_latch | undervolt | ~shutdown_n; // R2 R17 R20

  // Both high means both off, no error raised
  assign want_high = filt_cmd.high & ~filt_cmd.low & ~block; // R10 R12
  assign want_low  = filt_cmd.low & ~filt_cmd.high & ~block; // R10 R12

  // ----------------------------------------------------------------------
  // Interlock: cycles since the opposite gate went off
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] off_cnt_high;
  logic [CNT_W-1:0] off_cnt_low;
  logic             gate_high;
  logic             gate_low;

  // Saturates at dead time so an idle opposite side costs no delay
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      off_cnt_high <= CNT_W'(DEAD_CYC);
    end else if (gate_high) begin
      off_cnt_high <= '0;
    end else if (off_cnt_high != CNT_W'(DEAD_CYC)) begin
      off_cnt_high <= off_cnt_high + 1'b1; // R8
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      off_cnt_low <= CNT_W'(DEAD_CYC);
    end else if (gate_low) begin
      off_cnt_low <= '0;
    end else if (off_cnt_low != CNT_W'(DEAD_CYC)) begin
      off_cnt_low <= off_cnt_low + 1'b1; // R8
    end
  end

  logic next_gate_high;
  logic next_gate_low;
  logic hs_trip;
  logic ls_trip;

  // Dead time counts from opposite turn-off, so the controller gap
  // overlaps it rather than adding to it
  always_comb begin
    next_gate_high = want_high & ~gate_low & ~hs_trip
                     & (off_cnt_low == CNT_W'(DEAD_CYC)); // R6 R7 R11 R13
    next_gate_low  = want_low & ~gate_high & ~ls_trip
                     & (off_cnt_high == CNT_W'(DEAD_CYC)); // R6 R7 R11 R13
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gate_high <= GATE_RST;
      gate_low  <= GATE_RST;
    end else begin
      gate_high <= next_gate_high; // R1
      gate_low  <= next_gate_low;  // R1
    end
  end

  // ----------------------------------------------------------------------
  // Desaturation guards
  // ----------------------------------------------------------------------
  hbgp_desat_guard u_guard_high (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .gate_on (gate_high),
    .desat   (hs_sense),
    .trip    (hs_trip)
  );

  hbgp_desat_guard u_guard_low (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .gate_on (gate_low),
    .desat   (ls_sense),
    .trip    (ls_trip)
  );

  // ----------------------------------------------------------------------
  // Error latch and clear sequence
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] clr_cnt;
  logic             clr_done;
  logic             err_set;

  assign err_set  = undervolt | hs_trip | ls_trip; // R3 R15
  assign clr_done = (clr_cnt == CNT_W'(CLR_CYC));

  // Counts raw sampled lows so the filter does not lengthen the wait
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      clr_cnt <= '0;
    end else if (sync2_cmd.high | sync2_cmd.low) begin
      clr_cnt <= '0;
    end else if (!clr_done) begin
      clr_cnt <= clr_cnt + 1'b1; // R18
    end
  end

  // Set wins over clear
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      err_latch <= ERR_RST;
    end else if (err_set) begin
      err_latch <= 1'b1; // R3 R15
    end else if (clr_done) begin
      err_latch <= 1'b0; // R18
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HIGH_SIDE_GATE_ON_OUT  <= 1'b0;
      HIGH_SIDE_GATE_OFF_OUT <= 1'b1;
      LOW_SIDE_GATE_ON_OUT   <= 1'b0;
      LOW_SIDE_GATE_OFF_OUT  <= 1'b1;
    end else begin
      HIGH_SIDE_GATE_ON_OUT  <= next_gate_high;
      HIGH_SIDE_GATE_OFF_OUT <= ~next_gate_high;
      LOW_SIDE_GATE_ON_OUT   <= next_gate_low;
      LOW_SIDE_GATE_OFF_OUT  <= ~next_gate_low;
    end
  end

  // Pin pulled low while healthy, released on error
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FAULT_FLAG_OUT  <= 1'b0;
      FAULT_FLAG_OE_N <= 1'b0;
    end else begin
      FAULT_FLAG_OUT  <= 1'b0;
      FAULT_FLAG_OE_N <= err_latch | err_set; // R3 R19
    end
  end

endmodule : hbgp_top
`default_nettype wire

// ### tb/hbgp_ctrl_model.sv
// Controller model driving the two switching commands
`default_nettype none
module hbgp_ctrl_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Wanted pattern
  input  wire logic comp,
  input  wire logic want_h,
  input  wire logic want_l,
  // Commands
  output logic      cmd_h,
  output logic      cmd_l
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------
  // Commands
  // ------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_h <= 1'h0;
      cmd_l <= 1'h0;
    end else begin
      cmd_h <= want_h;
      cmd_l <= comp ? !want_h : want_l;
    end
  end
endmodule : hbgp_ctrl_model
`default_nettype wire

// ### tb/hbgp_asserts.sv
// Port checker for the gate protection block
`default_nettype none
module hbgp_asserts
  import hbgp_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Inputs
  input wire logic HIGH_SIDE_COMMAND_IN,
  input wire logic LOW_SIDE_COMMAND_IN,
  input wire logic SHUTDOWN_REQUEST_IN_N,
  input wire logic SUPPLY_UNDERVOLTAGE,
  // Outputs
  input wire logic HIGH_SIDE_GATE_ON_OUT,
  input wire logic HIGH_SIDE_GATE_OFF_OUT,
  input wire logic LOW_SIDE_GATE_ON_OUT,
  input wire logic LOW_SIDE_GATE_OFF_OUT,
  input wire logic FAULT_FLAG_OUT,
  input wire logic FAULT_FLAG_OE_N
);
  localparam int DEAD_MIN = DEAD_CYC - 1;
  wire logic  hon = HIGH_SIDE_GATE_ON_OUT;
  wire logic  lon = LOW_SIDE_GATE_ON_OUT;
  wire logic  foe = FAULT_FLAG_OE_N;
  logic [7:0] lo_off;
  logic [7:0] hi_off;
  logic [3:0] both;
  // ------------
  // Off and overlap counters
  // ------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lo_off <= 8'h00;
      hi_off <= 8'h00;
      both   <= 4'h0;
    end else begin
      lo_off <= lon ? 8'h00 : lo_off + {7'h00, lo_off != 8'hFF};
      hi_off <= hon ? 8'h00 : hi_off + {7'h00, hi_off != 8'hFF};
      both   <= (HIGH_SIDE_COMMAND_IN && LOW_SIDE_COMMAND_IN) ?
                both + {3'h0, both != 4'hF} : 4'h0;
    end
  end
  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_uv_held;
    SUPPLY_UNDERVOLTAGE [*4];
  endsequence
  sequence s_gates_off;
    !hon && !lon;
  endsequence
  property p_overlap; !(hon && lon); endproperty
  a_overlap: assert property (p_overlap)
    else $error("both gates on");
  property p_uv_off; s_uv_held |-> s_gates_off; endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("gate on under low supply");
  property p_uv_flag; s_uv_held |=> foe; endproperty
  a_uv_flag: assert property (p_uv_flag)
    else $error("no fault on low supply");
  property p_sd_off; !SHUTDOWN_REQUEST_IN_N [*4] |-> s_gates_off; endproperty
  a_sd_off: assert property (p_sd_off)
    else $error("gate on under shutdown");
  property p_flag_drive; !foe |-> FAULT_FLAG_OUT == 1'h0; endproperty
  a_flag_drive: assert property (p_flag_drive)
    else $error("fault pin driven high");
  property p_off_pair; HIGH_SIDE_GATE_OFF_OUT == !hon; endproperty
  a_off_pair: assert property (p_off_pair)
    else $error("off output not inverse");
  property p_off_pair_lo; LOW_SIDE_GATE_OFF_OUT == !lon; endproperty
  a_off_pair_lo: assert property (p_off_pair_lo)
    else $error("low off output not inverse");
  property p_both; both == 4'hF |-> s_gates_off; endproperty
  a_both: assert property (p_both)
    else $error("gate on with both commands");
  property p_blocked; $rose(hon) || $rose(lon) |-> !$past(foe); endproperty
  a_blocked: assert property (p_blocked)
    else $error("gate on while error latched");
  property p_dead_hi; $rose(hon) |-> lo_off >= DEAD_MIN; endproperty
  a_dead_hi: assert property (p_dead_hi)
    else $error("high gate dead time short");
  property p_dead_lo; $rose(lon) |-> hi_off >= DEAD_MIN; endproperty
  a_dead_lo: assert property (p_dead_lo)
    else $error("low gate dead time short");
endmodule : hbgp_asserts
bind hbgp_top hbgp_asserts u_hbgp_asserts (.*);
`default_nettype wire

// ### tb/hbgp_bench.sv
// Self-checking bench for the gate protection block
`default_nettype none
module hbgp_bench
  import hbgp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       rst_n = 1'h0;
  logic       sd_n  = 1'h1;
  logic       uv    = 1'h0;
  logic       hs    = 1'h0;
  logic       comp  = 1'h0;
  logic       wh    = 1'h0;
  logic       wl    = 1'h0;
  logic       ch, cl, hon, hoff, lon, loff, fout, foe, pin, seen;
  int         n_errors, tests_run, cycles, n;
  logic [4:0] rows [6] = '{5'h14, 5'h00, 5'h0A, 5'h18, 5'h14, 5'h0A};
  // Pull-up wins when the pin is released
  assign pin = foe ? 1'h1 : fout;
  hbgp_ctrl_model u_hbgp_ctrl_model (.clk(clk), .rst_n(rst_n),
    .comp(comp), .want_h(wh), .want_l(wl), .cmd_h(ch), .cmd_l(cl));
  hbgp_top u_hbgp_top (.SYS_CLK(clk), .RST_N(rst_n),
    .HIGH_SIDE_COMMAND_IN(ch), .LOW_SIDE_COMMAND_IN(cl),
    .SHUTDOWN_REQUEST_IN_N(sd_n), .SUPPLY_UNDERVOLTAGE(uv),
    .HIGH_SIDE_COLLECTOR_SENSE(hs),
    .LOW_SIDE_COLLECTOR_SENSE(1'h0),
    .HIGH_SIDE_GATE_ON_OUT(hon), .HIGH_SIDE_GATE_OFF_OUT(hoff),
    .LOW_SIDE_GATE_ON_OUT(lon), .LOW_SIDE_GATE_OFF_OUT(loff),
    .FAULT_FLAG_IN(pin), .FAULT_FLAG_OUT(fout), .FAULT_FLAG_OE_N(foe));
  // ------------
  // Tasks
  // ------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task automatic set(input logic h, input logic l);
    @(posedge clk);
    wh <= h;
    wl <= l;
  endtask : set
  task automatic chk(input string s, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", s, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string s, input int lo, input int hi);
    tests_run++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", s, lo, hi, n);
    end
  endtask : chk_rng
  task automatic rise(input logic low);
    n = 0;
    while ((low ? lon : hon) !== 1'h1 && n < 80) begin
      @(posedge clk);
      n++;
    end
  endtask : rise
  task automatic pulse(input logic v, input int k);
    set(v, 1'h0);
    cyc(k - 1);
    set(!v, 1'h0);
    seen = 1'h0;
    repeat (25) begin
      @(posedge clk);
      seen = seen | (hon === v);
    end
  endtask : pulse
  task automatic clr();
    set(1'h0, 1'h0);
    cyc(100);
  endtask : clr
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ------------
  // Clock and watchdog
  // ------------
  initial begin
    clk = 1'h0;
    forever #50 clk = !clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ------------
  // Main sequence
  // ------------
  initial begin
    cyc(5);
    rst_n <= 1'h1;
    clr();
    chk("flag", 1'h0, pin);
    $display("test reset done");
    foreach (rows[i]) begin
      set(rows[i][4], rows[i][3]);
      cyc(40);
      chk("high on", rows[i][2], hon);
      chk("low on", rows[i][1], lon);
      chk("flag", rows[i][0], pin);
    end
    $display("test table done");
    set(1'h0, 1'h0);
    cyc(30);
    set(1'h0, 1'h1);
    rise(1'h1);
    chk_rng("gap latency", FILT_CYC + 2, FILT_CYC + 9);
    set(1'h1, 1'h0);
    comp <= 1'h1;
    rise(1'h0);
    chk_rng("dead latency", DEAD_CYC + FILT_CYC, DEAD_CYC + FILT_CYC + 7);
    chk("low on", 1'h0, lon);
    comp <= 1'h0;
    $display("test latency done");
    clr();
    pulse(1'h1, 5);
    chk("short on", 1'h0, seen);
    pulse(1'h1, 8);
    chk("long on", 1'h1, seen);
    set(1'h1, 1'h0);
    cyc(30);
    pulse(1'h0, 5);
    chk("short off", 1'h0, seen);
    $display("test glitch done");
    set(1'h0, 1'h0);
    cyc(30);
    set(1'h1, 1'h0);
    rise(1'h0);
    hs <= 1'h1;
    cyc(15);
    chk("blanked", 1'h1, hon);
    cyc(20);
    chk("tripped", 1'h0, hon);
    chk("flag", 1'h1, pin);
    hs <= 1'h0;
    set(1'h0, 1'h1);
    cyc(40);
    chk("low on", 1'h0, lon);
    set(1'h0, 1'h0);
    cyc(80);
    chk("flag", 1'h1, pin);
    cyc(20);
    chk("flag", 1'h0, pin);
    $display("test desat done");
    set(1'h1, 1'h0);
    cyc(40);
    uv <= 1'h1;
    cyc(6);
    chk("high on", 1'h0, hon);
    chk("flag", 1'h1, pin);
    set(1'h0, 1'h1);
    cyc(40);
    chk("low on", 1'h0, lon);
    uv <= 1'h0;
    clr();
    chk("flag", 1'h0, pin);
    $display("test undervoltage done");
    set(1'h1, 1'h0);
    cyc(40);
    sd_n <= 1'h0;
    cyc(6);
    chk("high on", 1'h0, hon);
    chk("flag", 1'h0, pin);
    sd_n <= 1'h1;
    cyc(20);
    chk("high on", 1'h1, hon);
    $display("test shutdown done");
    rst_n <= 1'h0;
    cyc(2);
    chk("high on", 1'h0, hon);
    chk("high off", 1'h1, hoff);
    rst_n <= 1'h1;
    clr();
    chk("flag", 1'h0, pin);
    $display("test restart done");
    report_and_stop();
  end
endmodule : hbgp_bench
`default_nettype wire
